/* hdl/sixsw_consts.svh */
`ifndef SIXSW_CONSTS_SVH
`define SIXSW_CONSTS_SVH
`define SIXSW_FRAME_BITS   8
`define SIXSW_POWER_CH     6
`define SIXSW_ALL_CH       8
`define SIXSW_BITCNT_W     3
`define SIXSW_CMD_RESET    8'h00
`define SIXSW_FAULT_RESET  8'h00
`endif

/* hdl/sixsw_pkg.sv */
package sixsw_pkg;
  `include "sixsw_consts.svh"

  // Per-channel analog sense flags, one bit per channel.
  typedef struct packed {
    logic [`SIXSW_ALL_CH-1:0] shorted;
    logic [`SIXSW_ALL_CH-1:0] open_load;
  } sixsw_sense_t;

  // Pair inputs for the pair-control mode.
  typedef struct packed {
    logic pair_input_c;
    logic pair_input_b;
    logic pair_input_a;
  } sixsw_pair_t;
endpackage

/* hdl/sixsw_ctrl.sv */
`timescale 1ns/10ps
`include "sixsw_consts.svh"
module sixsw_ctrl
  import sixsw_pkg::*;
(
  // System clock and reset.
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  // Serial link from the host, clocked by the link clock.
  input  wire logic                      i_sclk,
  input  wire logic                      i_cs_n,
  input  wire logic                      i_si,
  output logic                           o_so,
  output logic                           o_so_oe_n,
  // Pins from the outside world.
  input  wire logic                      i_mode_sel,
  input  wire logic [`SIXSW_ALL_CH-1:0]  i_parallel_input,
  input  wire sixsw_pair_t               i_pair,
  input  wire logic                      i_overvoltage,
  input  wire sixsw_sense_t              i_sense,
  // Switch drive, active low outputs and gate drives.
  output logic [`SIXSW_ALL_CH-1:0]       o_switch_output_n,
  output logic [`SIXSW_ALL_CH-1:0]       o_gate_drive
);

  // ----------------------------------------------------------------
  // Link domain: shift register on the serial clock.
  // ----------------------------------------------------------------
  logic [`SIXSW_FRAME_BITS-1:0] fault_sync2_reg; // Live fault word, system side.
  logic [`SIXSW_FRAME_BITS-1:0] rx_reg;          // Incoming command shift.
  logic [`SIXSW_BITCNT_W-1:0]   bit_cnt_reg;     // Rising edges seen this frame.
  logic [`SIXSW_BITCNT_W-1:0]   fall_cnt_reg;    // Falling edges seen this frame.
  logic                         echo_phase_reg;  // A whole byte is in; echo it.
  logic                         frame_tgl_reg;   // Toggles per whole byte received.
  logic [`SIXSW_FRAME_BITS-1:0] snap_cmd_reg;    // Held for the system side.
  logic [`SIXSW_FRAME_BITS-1:0] fault_cap_reg;   // Fault word frozen at select.

  // Next value of the receive shift, most significant bit arriving first.
  wire [`SIXSW_FRAME_BITS-1:0] rx_next = {rx_reg[`SIXSW_FRAME_BITS-2:0], i_si};

  // Frame position, cleared by chip select so nothing depends on a clock
  // edge outside a frame.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_reg    <= '0;
      echo_phase_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == 3'h7) begin
        echo_phase_reg <= 1'b1;
      end
    end
  end

  // Command shift and frame hand-off; system reset gives the power-on
  // values, so the toggle and its synchroniser always agree after reset.
  always_ff @(posedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_reg        <= `SIXSW_CMD_RESET;
      snap_cmd_reg  <= `SIXSW_CMD_RESET;
      frame_tgl_reg <= 1'b0;
    end else if (!i_cs_n) begin
      rx_reg <= rx_next;
      if (bit_cnt_reg == 3'h7) begin
        snap_cmd_reg  <= rx_next;
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  // Fault word is frozen at the falling chip select edge so faults cannot
  // change under a frame in progress.
  always_ff @(negedge i_cs_n) begin
    fault_cap_reg <= fault_sync2_reg;
  end

  // Falling edges move the status to its next bit.
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      fall_cnt_reg <= '0;
    end else begin
      fall_cnt_reg <= fall_cnt_reg + 1'b1;
    end
  end

  // Status first, most significant bit first; once a whole byte is in, the
  // received bytes feed straight through so a longer frame echoes them.
  wire so_bit = echo_phase_reg ? rx_reg[`SIXSW_FRAME_BITS-1]
                               : fault_cap_reg[~fall_cnt_reg];

  // ----------------------------------------------------------------
  // Crossing into the system clock domain.
  // ----------------------------------------------------------------
  logic                         tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic                         cs_s1_reg, cs_s2_reg;
  logic                         mode_s1_reg, mode_s2_reg;
  logic                         ov_s1_reg, ov_s2_reg;
  logic [`SIXSW_ALL_CH-1:0]     par_s1_reg, par_s2_reg;
  sixsw_pair_t                  pair_s1_reg, pair_s2_reg;
  sixsw_sense_t                 sense_s1_reg, sense_s2_reg;
  logic [`SIXSW_FRAME_BITS-1:0] pend_cmd_reg;   // Frame taken, not yet loaded.
  logic [`SIXSW_FRAME_BITS-1:0] cmd_reg;        // Command in force.
  logic                         ov_latch_reg;   // Overvoltage shutdown latch.
  logic                         cs_prev_reg;

  // Two-flop synchronisers for every pin and for the frame toggle.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= 3'h0;
      {cs_s1_reg, cs_s2_reg, cs_prev_reg}  <= 3'h7;
      {mode_s1_reg, mode_s2_reg}           <= 2'h0;
      {ov_s1_reg, ov_s2_reg}               <= 2'h0;
      {par_s1_reg, par_s2_reg}             <= '0;
      {pair_s1_reg, pair_s2_reg}           <= '0;
      {sense_s1_reg, sense_s2_reg}         <= '0;
    end else begin
      tgl_s1_reg   <= frame_tgl_reg;
      tgl_s2_reg   <= tgl_s1_reg;
      tgl_s3_reg   <= tgl_s2_reg;
      cs_s1_reg    <= i_cs_n;
      cs_s2_reg    <= cs_s1_reg;
      cs_prev_reg  <= cs_s2_reg;
      mode_s1_reg  <= i_mode_sel;
      mode_s2_reg  <= mode_s1_reg;
      ov_s1_reg    <= i_overvoltage;
      ov_s2_reg    <= ov_s1_reg;
      par_s1_reg   <= i_parallel_input;
      par_s2_reg   <= par_s1_reg;
      pair_s1_reg  <= i_pair;
      pair_s2_reg  <= pair_s1_reg;
      sense_s1_reg <= i_sense;
      sense_s2_reg <= sense_s1_reg;
    end
  end

  wire frame_done = tgl_s2_reg ^ tgl_s3_reg;      // One pulse per byte received.
  wire cs_rise    = cs_s2_reg & ~cs_prev_reg;     // Chip select released.

  // ----------------------------------------------------------------
  // Channel decision.
  // ----------------------------------------------------------------
  logic [`SIXSW_ALL_CH-1:0] want_on;   // Requested state per channel.
  logic [`SIXSW_ALL_CH-1:0] gate_next; // Gate drive after protection.
  logic [`SIXSW_ALL_CH-1:0] fault_now; // Live fault per channel.

  genvar ch;
  generate
    for (ch = 0; ch < `SIXSW_ALL_CH; ch++) begin : g_ch
      if (ch < `SIXSW_POWER_CH) begin : g_pw
        // Pair inputs win in mode high, else serial OR parallel.
        assign want_on[ch] = mode_s2_reg ? pair_s2_reg[ch/2]
                                         : (cmd_reg[ch] | par_s2_reg[ch]);
      end else begin : g_lp
        // Low-power channels ignore serial bits and go off in mode high.
        assign want_on[ch] = ~mode_s2_reg & par_s2_reg[ch];
      end
      // Shorted while on reports and forces off; open while off reports.
      assign fault_now[ch] = (want_on[ch] & sense_s2_reg.shorted[ch])
                           | (~want_on[ch] & sense_s2_reg.open_load[ch]);
      assign gate_next[ch] = want_on[ch] & ~sense_s2_reg.shorted[ch]
                           & ~ov_latch_reg & ~ov_s2_reg;
    end
  endgenerate

  // Commands load only at chip select release; overvoltage latches off.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_cmd_reg    <= `SIXSW_CMD_RESET;
      cmd_reg         <= `SIXSW_CMD_RESET;
      fault_sync2_reg <= `SIXSW_FAULT_RESET;
      ov_latch_reg    <= 1'b0;
      o_gate_drive      <= '0;
      o_switch_output_n <= '1;
    end else begin
      if (frame_done) pend_cmd_reg <= snap_cmd_reg;
      if (cs_rise) cmd_reg <= frame_done ? snap_cmd_reg : pend_cmd_reg;
      fault_sync2_reg   <= fault_now;
      ov_latch_reg      <= ov_latch_reg | ov_s2_reg;
      o_gate_drive      <= gate_next;
      o_switch_output_n <= ~gate_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial output pin: the echo of the prior command follows status.
  // ----------------------------------------------------------------
  // Drive only when selected and mode low; the pull-up then reads ones.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_so      <= 1'b0;
      o_so_oe_n <= 1'b1;
    end else begin
      o_so      <= so_bit;
      o_so_oe_n <= cs_s2_reg | mode_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks on the system side.
  // ----------------------------------------------------------------
  // A latched overvoltage keeps every gate off.
  property p_ov_gates_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      ov_latch_reg |=> (o_gate_drive == 8'h00);
  endproperty
  a_ov_gates_off: assert property (p_ov_gates_off)
    else $error("gate drive on while overvoltage latched");

  // Output pins are always the inverse of the gates.
  property p_outputs_inverse;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_switch_output_n == ~o_gate_drive;
  endproperty
  a_outputs_inverse: assert property (p_outputs_inverse)
    else $error("output pins not inverse of gate drive");

  // Low-power channels are off in pair mode.
  property p_lowpower_off_in_mode;
    @(posedge i_clk) disable iff (i_sys_rst)
      mode_s2_reg |=> (o_gate_drive[7:6] == 2'b00);
  endproperty
  a_lowpower_off_in_mode: assert property (p_lowpower_off_in_mode)
    else $error("low-power channel on in pair mode");

  // Each pair input drives both of its channels.
  property p_pair_drive;
    @(posedge i_clk) disable iff (i_sys_rst)
      (mode_s2_reg && !ov_latch_reg && !ov_s2_reg && (sense_s2_reg.shorted == 8'h00))
      |=> (o_gate_drive[5:0] == {{2{$past(pair_s2_reg.pair_input_c)}},
                                 {2{$past(pair_s2_reg.pair_input_b)}},
                                 {2{$past(pair_s2_reg.pair_input_a)}}});
  endproperty
  a_pair_drive: assert property (p_pair_drive)
    else $error("pair input not driving its two channels");

  // A shorted channel never has its gate on.
  property p_short_forces_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      (sense_s2_reg.shorted != 8'h00)
      |=> ((o_gate_drive & $past(sense_s2_reg.shorted)) == 8'h00);
  endproperty
  a_short_forces_off: assert property (p_short_forces_off)
    else $error("gate on while channel shorted");

  // The command in force changes only at chip select release.
  property p_cmd_holds;
    @(posedge i_clk) disable iff (i_sys_rst)
      !cs_rise |=> $stable(cmd_reg);
  endproperty
  a_cmd_holds: assert property (p_cmd_holds)
    else $error("command changed without chip select release");

  // The serial output is released in pair mode.
  property p_so_released_in_mode;
    @(posedge i_clk) disable iff (i_sys_rst)
      mode_s2_reg |=> o_so_oe_n;
  endproperty
  a_so_released_in_mode: assert property (p_so_released_in_mode)
    else $error("serial output driven in pair mode");

endmodule

/* verification/sixsw_host.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host serial master, one 8-bit or 16-bit frame at a time.
// ------------------------------------------------------------
module sixsw_host (
  // Serial link toward the device.
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  // Link clock stands low and the device is deselected between frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // Frame of 160 ns link periods, most significant bit first.
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
    o_cs_n = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--) begin
      o_si = cmd[i];
      #80 o_sclk = 1'b1;
      rx[i] = i_so;
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_si = 1'b0;  // The pulled-down level once released.
    #1000;  // The gap keeps frames apart and lets outputs settle.
  endtask

  // Double-length frame; the second byte returned echoes the first sent.
  task automatic xfer16(input logic [15:0] cmd, output logic [15:0] rx);
    o_cs_n = 1'b0;
    #160;
    for (int i = 15; i >= 0; i--) begin
      o_si = cmd[i];
      #80 o_sclk = 1'b1;
      rx[i] = i_so;
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_si = 1'b0;
    #1000;
  endtask
endmodule

/* verification/sixsw_ctrl_tb_top.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bench for the switch control block.
// ------------------------------------------------------------
module sixsw_ctrl_tb_top;
  import sixsw_pkg::*;
  // Pins, all given a value at time zero.
  logic         clk   = 1'b0;
  logic         rst   = 1'b1;
  logic         mode  = 1'b0;
  logic         ov    = 1'b0;
  logic [7:0]   par   = 8'h00;
  sixsw_pair_t  pair  = '0;
  sixsw_sense_t sense = '0;
  logic [7:0]   rx;
  logic [15:0]  rx16;
  wire          sclk, cs_n, si, so, so_oe_n, so_w;
  wire  [7:0]   out_n, gate;
  int           err_total = 0;
  int           n_tests   = 0;

  // The serial line is pulled up whenever the device releases it.
  assign so_w = so_oe_n ? 1'b1 : so;
  always #20 clk = ~clk;

  sixsw_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_w));
  sixsw_ctrl u_dut (.i_clk(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n), .i_mode_sel(mode),
    .i_parallel_input(par), .i_pair(pair), .i_overvoltage(ov), .i_sense(sense),
    .o_switch_output_n(out_n), .o_gate_drive(gate));

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Sends a command and checks gates and the active low pins.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] eg);
    u_host.xfer(cmd, rx);
    chk("gate", eg, gate);
    chk("out_n", ~eg, out_n);
  endtask

  // Serial and parallel control, with pair inputs active but ignored.
  task automatic t_normal;
    @(posedge clk) #2 pair = 3'h7;
    frame(8'h3F, 8'h3F);
    @(posedge clk) #2 par = 8'hC5;
    frame(8'hC0, 8'hC5);
    frame(8'h2A, 8'hEF);
    $display("t_normal done");
  endtask

  // A short while on and an open load while off both report.
  task automatic t_fault;
    @(posedge clk) #2 par = 8'h00;
    sense.shorted   = 8'h01;
    sense.open_load = 8'h80;
    frame(8'h01, 8'h00);
    frame(8'h01, 8'h00);
    chk("status", 8'h81, rx);
    @(posedge clk) #2 sense = '0;
    $display("t_fault done");
  endtask

  // Pair mode overrides everything, yet serial commands are still taken.
  task automatic t_mode;
    @(posedge clk) #2 mode = 1'b1;
    pair = 3'h5;
    par  = 8'hFF;
    frame(8'h12, 8'h33);
    chk("status", 8'hFF, rx);
    @(posedge clk) #2 mode = 1'b0;
    par = 8'h00;
    repeat (8) @(posedge clk);
    chk("gate", 8'h12, gate);
    $display("t_mode done");
  endtask

  // A double frame returns status then the first byte; the second is loaded.
  task automatic t_echo;
    @(posedge clk) #2;
    u_host.xfer16(16'h150C, rx16);
    chk("echo", 8'h15, rx16[7:0]);
    chk("status", 8'h00, rx16[15:8]);
    chk("gate", 8'h0C, gate);
    $display("t_echo done");
  endtask

  // Overvoltage latches every gate off until the next reset.
  task automatic t_ov;
    @(posedge clk) #2 par = 8'hFF;
    ov = 1'b1;
    repeat (8) @(posedge clk);
    chk("gate", 8'h00, gate);
    @(posedge clk) #2 ov = 1'b0;
    frame(8'h3F, 8'h00);
    @(posedge clk) #2 rst = 1'b1;
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    repeat (8) @(posedge clk);
    chk("gate", 8'hFF, gate);
    $display("t_ov done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Guards against a hang; running out counts as a mismatch.
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    repeat (3) @(posedge clk);
    t_normal();
    t_fault();
    t_mode();
    t_echo();
    t_ov();
    print_verdict();
  end
endmodule
